// *** logic/dst_pkg.sv ***
// shared constants, types and the baud decode helper for the serial telegram slave
// assumes a 100 MHz system clock; all users import the whole package
package dst_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DIV_W = 17;
    localparam int CHAR_BITS = 11;
    localparam int GAP_CHARS = 2;
    localparam int GAP_BITS = GAP_CHARS * CHAR_BITS;
    localparam int RESP_MAX_MS = 20;
    localparam int RESP_MAX_CYC = (RESP_MAX_MS * 1_000_000) / CLK_PERIOD_NS;
    localparam int DUR_NUM = 3;
    localparam int DUR_DEN = 2;
    localparam int HDR_BYTES = 2;
    localparam int MAX_LEN_DEFAULT = 255;
    localparam int MAX_SLAVES_DIRECT = 31;
    localparam int MAX_SLAVES_REPEATER = 126;
    localparam logic [7:0] STX_BYTE = 8'h02;
    localparam logic [7:0] LEN_MIN = 8'h02;
    localparam logic [7:0] LEN_OVERHEAD = 8'h02;
    localparam logic [7:0] TX_FRAME_EXTRA = 8'h04;
    localparam logic [7:0] TX_ADDR_IDX = 8'h02;
    localparam logic [3:0] PAR_IDX = 4'h9;
    localparam logic [3:0] STOP_IDX = 4'hA;
    localparam logic [3:0] TX_SHIFT_BITS = 4'hA;
    localparam int FORMAT_BIT = 7;
    localparam int SHORT_BCAST_BIT = 5;

    typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_SHIFT = 1'b1} dst_rx_state_t;
    typedef enum logic [1:0] {T_STX = 2'b00, T_LEN = 2'b01, T_ADDR = 2'b10, T_BODY = 2'b11} dst_tg_state_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_CHAR = 2'b10} dst_tx_state_t;
    typedef enum logic [2:0]
    {
        ERR_NONE = 3'b000,
        ERR_PARITY = 3'b001,
        ERR_FRAME = 3'b010,
        ERR_LENGTH = 3'b011,
        ERR_GAP = 3'b100,
        ERR_CHECK = 3'b101,
        ERR_DURATION = 3'b110
    } dst_err_t;

    // bit period in clocks for each baud selection
    function automatic logic [DIV_W-1:0] dst_baud_div(input logic [2:0] sel);
        case (sel)
            3'h0: dst_baud_div = DIV_W'(CLK_HZ / 1200);
            3'h1: dst_baud_div = DIV_W'(CLK_HZ / 2400);
            3'h2: dst_baud_div = DIV_W'(CLK_HZ / 4800);
            3'h3: dst_baud_div = DIV_W'(CLK_HZ / 9600);
            3'h4: dst_baud_div = DIV_W'(CLK_HZ / 19200);
            3'h5: dst_baud_div = DIV_W'(CLK_HZ / 38400);
            3'h6: dst_baud_div = DIV_W'(CLK_HZ / 57600);
            default: dst_baud_div = DIV_W'(CLK_HZ / 115200);
        endcase
    endfunction
endpackage

// *** logic/dst_tick_if.sv ***
// bit timer control and tick between the slave core and its bit timers
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface dst_tick_if;
    import dst_pkg::*;
    logic restart;
    logic half;
    logic [DIV_W-1:0] div;
    logic tick;
    modport owner (output restart, output half, output div, input tick);
    modport timer (input restart, input half, input div, output tick);
endinterface

// *** logic/dst_bit_timer.sv ***
// free-running bit period timer with restart to half or full period
// assumes div is at least 2 and stable within a character
`timescale 1ns/1ps
module dst_bit_timer
    import dst_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    dst_tick_if.timer tif
);
    logic [DIV_W-1:0] count_reg;
    logic tick_reg;

    assign tif.tick = tick_reg;

    // --------------------------------------------------------------
    // period counter
    // --------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end
        else if (tif.restart)
        begin
            count_reg <= tif.half ? (tif.div >> 1) : (tif.div - DIV_W'(1));
            tick_reg <= 1'b0;
        end
        else if (count_reg == '0)
        begin
            count_reg <= tif.div - DIV_W'(1);
            tick_reg <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg - DIV_W'(1);
            tick_reg <= 1'b0;
        end
    end
endmodule

// *** logic/dst_slave.sv ***
// slave framer for the drive_serial_protocol master/slave telegram link
// assumes rx_line synchronous to clock, idle high; tx_drive_en steers the line driver
//
// Behaviour
// - own address spans 1 to 126, so 31 direct or 126 repeated slaves fit.
// - a reply is sent only after a faultless telegram to our own address.
// - broadcast telegrams are accepted and never answered.
// - each character is start, eight data, parity, stop: eleven bit periods.
// - parity makes data plus parity hold even ones; mismatch is a fault.
// - telegram is 02 hex, length, address, data bytes, check byte.
// - bit rate comes from the configured baud selection, same as master.
// - reply starts at least two characters and within 20 ms after telegram.
// - character gaps over two characters or overlong telegrams are refused.
// - length byte equals data bytes plus address and check byte.
// - short format: bit7 zero, bit6 ignored, bit5 broadcast, else bits 0-4 match.
// - two address formats chosen by address bit 7.
// - long format: bit7 one, bits 0-6 address, zero means broadcast.
// - reply echoes the received address byte unchanged.
// - check byte is xor of all preceding bytes from zero, 02 included.
`timescale 1ns/1ps
module dst_slave
    import dst_pkg::*;
#(
    parameter int RESP_MAX = RESP_MAX_CYC,
    parameter int MAX_LEN = MAX_LEN_DEFAULT
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic rx_line,
    input wire logic [2:0] baud_select,
    input wire logic [6:0] own_address,
    input wire logic [7:0] reply_data_count,
    input wire logic [7:0] reply_data,
    output logic tx_line,
    output logic tx_drive_en,
    output logic reply_data_take,
    output logic [7:0] rx_data,
    output logic rx_data_valid,
    output logic telegram_ok,
    output logic telegram_broadcast,
    output logic telegram_error,
    output logic [2:0] error_code
);
    localparam int WAIT_W = $clog2(RESP_MAX + 1);

    // address byte decode: {match, broadcast}
    function automatic logic [1:0] dst_addr_decode(input logic [7:0] a, input logic [6:0] own);
        logic bc;
        logic hit;
        bc = 1'b0;
        hit = 1'b0;
        if (!a[FORMAT_BIT])
        begin
            bc = a[SHORT_BCAST_BIT];
            hit = !bc && own[6:5] == 2'b00 && own != 7'h00 && a[4:0] == own[4:0];
        end
        else
        begin
            bc = a[6:0] == 7'h00;
            hit = !bc && own != 7'h00 && a[6:0] == own;
        end
        dst_addr_decode = {hit, bc};
    endfunction

    dst_tick_if rx_tif ();
    dst_tick_if tx_tif ();

    dst_bit_timer u_rx_timer (.clock(clock), .reset_n(reset_n), .tif(rx_tif));
    dst_bit_timer u_tx_timer (.clock(clock), .reset_n(reset_n), .tif(tx_tif));

    // --------------------------------------------------------------
    // character receiver
    // --------------------------------------------------------------
    dst_rx_state_t rx_state_reg;
    logic rx_prev_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic rx_par_reg;
    logic char_done;
    logic parity_bad;
    logic frame_bad;

    assign rx_tif.div = dst_baud_div(baud_select);
    assign rx_tif.half = 1'b1;
    assign rx_tif.restart = rx_state_reg == RX_IDLE && rx_prev_reg && !rx_line;
    assign char_done = rx_state_reg == RX_SHIFT && rx_tif.tick && rx_bit_reg == STOP_IDX;
    assign parity_bad = (^rx_shift_reg) != rx_par_reg;
    assign frame_bad = !rx_line;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            rx_prev_reg <= 1'b1;
        else
            rx_prev_reg <= rx_line;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_state_reg <= RX_IDLE;
            rx_bit_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_par_reg <= 1'b0;
        end
        else
        begin
            case (rx_state_reg)
                RX_IDLE:
                begin
                    rx_bit_reg <= 4'h0;
                    if (rx_tif.restart)
                        rx_state_reg <= RX_SHIFT;
                end
                RX_SHIFT:
                begin
                    if (rx_tif.tick)
                    begin
                        if ((rx_bit_reg == 4'h0 && rx_line) || rx_bit_reg == STOP_IDX)
                            rx_state_reg <= RX_IDLE;
                        else
                        begin
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg == PAR_IDX)
                                rx_par_reg <= rx_line;
                            else if (rx_bit_reg != 4'h0)
                                rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // telegram assembly and checks
    // --------------------------------------------------------------
    dst_tg_state_t tg_state_reg;
    logic [7:0] remain_reg;
    logic [7:0] addr_reg;
    logic [7:0] running_check_sum;
    logic [4:0] gap_reg;
    logic [15:0] dur_reg;
    logic [15:0] dur_limit_reg;
    dst_err_t tg_err;
    logic tg_accept;
    logic dec_match;
    logic dec_bcast;
    logic [7:0] telegram_length_byte;

    assign telegram_length_byte = rx_shift_reg;
    assign {dec_match, dec_bcast} = dst_addr_decode(addr_reg, own_address);
    assign tg_accept = char_done && tg_err == ERR_NONE && tg_state_reg == T_BODY && remain_reg == 8'h01;

    always_comb
    begin
        tg_err = ERR_NONE;
        if (tg_state_reg != T_STX)
        begin
            if (rx_state_reg == RX_IDLE && gap_reg > 5'(GAP_BITS))
                tg_err = ERR_GAP;
            else if (tg_state_reg != T_LEN && dur_reg > dur_limit_reg)
                tg_err = ERR_DURATION;
            else if (char_done && parity_bad)
                tg_err = ERR_PARITY;
            else if (char_done && frame_bad)
                tg_err = ERR_FRAME;
            else if (char_done && tg_state_reg == T_LEN
                     && (telegram_length_byte < LEN_MIN || 32'(telegram_length_byte) > MAX_LEN))
                tg_err = ERR_LENGTH;
            else if (tg_accept_raw())
                tg_err = ERR_CHECK;
        end
    end

    function automatic logic tg_accept_raw();
        tg_accept_raw = char_done && tg_state_reg == T_BODY && remain_reg == 8'h01
                        && (running_check_sum ^ rx_shift_reg) != 8'h00;
    endfunction

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tg_state_reg <= T_STX;
            remain_reg <= 8'h00;
            addr_reg <= 8'h00;
            running_check_sum <= 8'h00;
            dur_limit_reg <= 16'h0000;
        end
        else if (tg_err != ERR_NONE)
            tg_state_reg <= T_STX;
        else if (char_done)
        begin
            running_check_sum <= running_check_sum ^ rx_shift_reg;
            case (tg_state_reg)
                T_STX:
                begin
                    running_check_sum <= rx_shift_reg;
                    if (!parity_bad && !frame_bad && rx_shift_reg == STX_BYTE)
                        tg_state_reg <= T_LEN;
                end
                T_LEN:
                begin
                    remain_reg <= telegram_length_byte;
                    dur_limit_reg <= 16'(((int'(telegram_length_byte) + HDR_BYTES) * CHAR_BITS * DUR_NUM) / DUR_DEN);
                    tg_state_reg <= T_ADDR;
                end
                T_ADDR:
                begin
                    addr_reg <= rx_shift_reg;
                    remain_reg <= remain_reg - 8'h01;
                    tg_state_reg <= T_BODY;
                end
                T_BODY:
                begin
                    remain_reg <= remain_reg - 8'h01;
                    if (remain_reg == 8'h01)
                        tg_state_reg <= T_STX;
                end
                default: tg_state_reg <= T_STX;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap_reg <= 5'h00;
            dur_reg <= 16'h0000;
        end
        else
        begin
            if (rx_tif.restart || tg_state_reg == T_STX)
                gap_reg <= 5'h00;
            else if (rx_state_reg == RX_IDLE && rx_tif.tick && gap_reg != 5'h1F)
                gap_reg <= gap_reg + 5'h01;
            if (tg_state_reg == T_STX)
                dur_reg <= 16'h0000;
            else if (rx_tif.tick && dur_reg != 16'hFFFF)
                dur_reg <= dur_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_data <= 8'h00;
            rx_data_valid <= 1'b0;
            telegram_ok <= 1'b0;
            telegram_broadcast <= 1'b0;
            telegram_error <= 1'b0;
            error_code <= ERR_NONE;
        end
        else
        begin
            rx_data_valid <= char_done && tg_err == ERR_NONE && tg_state_reg == T_BODY && remain_reg != 8'h01;
            if (char_done)
                rx_data <= rx_shift_reg;
            telegram_ok <= tg_accept;
            if (tg_accept)
                telegram_broadcast <= dec_bcast;
            telegram_error <= tg_err != ERR_NONE;
            if (tg_err != ERR_NONE)
                error_code <= tg_err;
        end
    end

    // --------------------------------------------------------------
    // reply transmitter
    // --------------------------------------------------------------
    dst_tx_state_t tx_state_reg;
    logic [7:0] tx_idx_reg;
    logic [7:0] tx_len_reg;
    logic [7:0] tx_sum_reg;
    logic [9:0] tx_shift_reg;
    logic [3:0] tx_cnt_reg;
    logic [4:0] tx_gap_reg;
    logic [WAIT_W-1:0] tx_wait_reg;
    logic arm;
    logic tx_load;
    logic [7:0] tx_byte;
    logic block_check_byte_slot;

    assign arm = tx_state_reg == TX_IDLE && tg_accept && dec_match && !dec_bcast;
    assign tx_tif.div = dst_baud_div(baud_select);
    assign tx_tif.half = 1'b0;
    assign tx_tif.restart = arm;
    assign block_check_byte_slot = tx_idx_reg == tx_len_reg + 8'h03;
    assign tx_load = tx_tif.tick && ((tx_state_reg == TX_WAIT && tx_gap_reg == 5'(GAP_BITS))
                     || (tx_state_reg == TX_CHAR && tx_cnt_reg == 4'h0 && tx_idx_reg != tx_len_reg + TX_FRAME_EXTRA));

    always_comb
    begin
        case (tx_idx_reg)
            8'h00: tx_byte = STX_BYTE;
            8'h01: tx_byte = tx_len_reg + LEN_OVERHEAD;
            TX_ADDR_IDX: tx_byte = addr_reg;
            default: tx_byte = block_check_byte_slot ? tx_sum_reg : reply_data;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state_reg <= TX_IDLE;
            tx_idx_reg <= 8'h00;
            tx_len_reg <= 8'h00;
            tx_sum_reg <= 8'h00;
            tx_shift_reg <= 10'h3FF;
            tx_cnt_reg <= 4'h0;
            tx_gap_reg <= 5'h00;
            tx_wait_reg <= '0;
            tx_line <= 1'b1;
            tx_drive_en <= 1'b0;
            reply_data_take <= 1'b0;
        end
        else
        begin
            reply_data_take <= tx_load && tx_idx_reg > TX_ADDR_IDX && !block_check_byte_slot;
            if (tx_load)
            begin
                tx_line <= 1'b0;
                tx_shift_reg <= {1'b1, ^tx_byte, tx_byte};
                tx_cnt_reg <= TX_SHIFT_BITS;
                tx_sum_reg <= tx_sum_reg ^ tx_byte;
                tx_idx_reg <= tx_idx_reg + 8'h01;
                tx_drive_en <= 1'b1;
                tx_state_reg <= TX_CHAR;
            end
            else
            begin
                case (tx_state_reg)
                    TX_IDLE:
                    begin
                        tx_gap_reg <= 5'h00;
                        tx_wait_reg <= '0;
                        tx_idx_reg <= 8'h00;
                        tx_sum_reg <= 8'h00;
                        if (arm)
                        begin
                            tx_len_reg <= reply_data_count;
                            tx_state_reg <= TX_WAIT;
                        end
                    end
                    TX_WAIT:
                    begin
                        tx_wait_reg <= tx_wait_reg + WAIT_W'(1);
                        if (32'(tx_wait_reg) == RESP_MAX - 1)
                            tx_state_reg <= TX_IDLE;
                        else if (tx_tif.tick)
                            tx_gap_reg <= tx_gap_reg + 5'h01;
                    end
                    TX_CHAR:
                    begin
                        if (tx_tif.tick && tx_cnt_reg != 4'h0)
                        begin
                            tx_line <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                            tx_cnt_reg <= tx_cnt_reg - 4'h1;
                        end
                        else if (tx_tif.tick)
                        begin
                            tx_drive_en <= 1'b0;
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                    default: tx_state_reg <= TX_IDLE;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_first_load;
        tx_load && tx_idx_reg == 8'h00;
    endsequence
    sequence s_bcast_accept;
        tg_accept && dec_bcast;
    endsequence

    property p_reply_cause;
        (tx_state_reg == TX_WAIT && $past(tx_state_reg) == TX_IDLE) |-> $past(tg_accept && dec_match && !dec_bcast);
    endproperty
    a_reply_cause: assert property (p_reply_cause) else $error("reply armed without own faultless telegram");

    property p_bcast_silent;
        s_bcast_accept |=> (tx_state_reg == TX_IDLE && !tx_drive_en) [*8];
    endproperty
    a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast answered");

    property p_start_bit;
        tx_load |=> !tx_line && tx_drive_en && tx_cnt_reg == TX_SHIFT_BITS;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("character does not open with start bit");

    property p_parity_reject;
        (char_done && parity_bad && tg_state_reg != T_STX && tg_err == ERR_PARITY)
            |=> telegram_error && error_code == ERR_PARITY && tg_state_reg == T_STX && !telegram_ok;
    endproperty
    a_parity_reject: assert property (p_parity_reject) else $error("parity fault not refused");

    property p_stx_first;
        s_first_load |=> tx_shift_reg[7:0] == STX_BYTE && tx_shift_reg[8] == 1'b1 && tx_shift_reg[9];
    endproperty
    a_stx_first: assert property (p_stx_first) else $error("reply does not begin with 02");

    property p_gap_before_reply;
        s_first_load |-> 32'(tx_wait_reg) >= ((GAP_BITS * 2 + 1) * 32'(tx_tif.div)) / 2 && !tx_drive_en;
    endproperty
    a_gap_before_reply: assert property (p_gap_before_reply) else $error("reply started too early");

    property p_resp_window;
        tx_state_reg == TX_WAIT |-> 32'(tx_wait_reg) < RESP_MAX;
    endproperty
    a_resp_window: assert property (p_resp_window) else $error("reply window overrun");

    property p_addr_echo;
        (tx_load && tx_idx_reg == TX_ADDR_IDX) |=> tx_shift_reg[7:0] == $past(addr_reg);
    endproperty
    a_addr_echo: assert property (p_addr_echo) else $error("address byte not echoed");

    property p_len_byte;
        (tx_load && tx_idx_reg == 8'h01) |=> tx_shift_reg[7:0] == tx_len_reg + LEN_OVERHEAD;
    endproperty
    a_len_byte: assert property (p_len_byte) else $error("reply length byte wrong");

    property p_check_ok;
        telegram_ok |-> $past(running_check_sum ^ rx_shift_reg) == 8'h00 && !telegram_error;
    endproperty
    a_check_ok: assert property (p_check_ok) else $error("telegram accepted with bad check byte");
endmodule

// *** testbench/dst_master_model.sv ***
// bus master model: sends telegrams on the slave receive line, collects replies
// assumes the 100 MHz clock and a bit period of DIV clocks
`timescale 1ns/1ps
module dst_master_model
#(
    parameter int DIV = 868
)
(
    input wire logic clock,
    output logic line,
    input wire logic tx_line,
    input wire logic tx_drive_en
);
    logic [7:0] rx_q[$];
    int bad_frames = 0;
    initial line = 1'b1;
    // ----------------------------------------
    // send one character, lsb first, back to back
    // ----------------------------------------
    task automatic send_byte(input logic [7:0] b, input logic bad_par);
        logic [10:0] f;
        f = {1'b1, ^b ^ bad_par, b, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(negedge clock);
            line = f[i];
            repeat (DIV - 1) @(negedge clock);
        end
    endtask
    // ----------------------------------------
    // reply receiver, samples mid-bit
    // ----------------------------------------
    always
    begin
        logic [10:0] f;
        @(negedge tx_line);
        repeat (DIV / 2) @(posedge clock);
        for (int i = 0; i < 11; i++)
        begin
            f[i] = tx_line;
            if (i < 10)
                repeat (DIV) @(posedge clock);
        end
        if (f[0] || !f[10] || (^f[9:1]) || !tx_drive_en)
            bad_frames++;
        rx_q.push_back(f[8:1]);
    end
endmodule

// *** testbench/tb_dst_slave.sv ***
// bench for the telegram slave: unicast with reply, broadcast, parity, length and check faults
// assumes dst_master_model on the line and the 115200 baud selection
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_dst_slave
    import dst_pkg::*;
();
    localparam int DIV = CLK_HZ / 115200;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic rx_line;
    logic [6:0] own_address = 7'h00;
    logic [7:0] reply_data_count = 8'h01;
    logic [7:0] reply_data = 8'h00;
    logic tx_line, tx_drive_en, reply_data_take, rx_data_valid, telegram_ok, telegram_broadcast, telegram_error;
    logic [7:0] rx_data;
    logic [2:0] error_code;
    logic [7:0] tg[$];
    logic [7:0] exp_q[$];
    logic [7:0] addr;
    int err_count = 0, num_checks = 0, cyc = 0, ok_n = 0, bad_n = 0, take_n = 0, val_n = 0, starts = 0;
    int t_ok = 0, t_tx = 0;
    initial forever #5 clock = ~clock;
    dst_slave u_dut (.clock(clock), .reset_n(reset_n), .rx_line(rx_line), .baud_select(3'h7),
        .own_address(own_address), .reply_data_count(reply_data_count), .reply_data(reply_data),
        .tx_line(tx_line), .tx_drive_en(tx_drive_en), .reply_data_take(reply_data_take), .rx_data(rx_data),
        .rx_data_valid(rx_data_valid), .telegram_ok(telegram_ok), .telegram_broadcast(telegram_broadcast),
        .telegram_error(telegram_error), .error_code(error_code));
    dst_master_model #(.DIV(DIV)) u_m (.clock(clock), .line(rx_line), .tx_line(tx_line), .tx_drive_en(tx_drive_en));
    // ----------------------------------------
    // event counters and timeout
    // ----------------------------------------
    always @(posedge clock)
    begin
        cyc++;
        if (telegram_ok === 1'b1) begin ok_n++; t_ok = cyc; end
        if (telegram_error === 1'b1) bad_n++;
        if (reply_data_take === 1'b1) take_n++;
        if (rx_data_valid === 1'b1) val_n++;
        if ($rose(tx_drive_en)) begin starts++; t_tx = cyc; end
        if (cyc == 400000) begin err_count++; results(); end
    end
    function automatic logic [7:0] xsum(input logic [7:0] q[$]);
        xsum = 8'h00;
        foreach (q[i]) xsum ^= q[i];
    endfunction
    task automatic send(input int bad_at);
        foreach (tg[i]) u_m.send_byte(tg[i], i == bad_at);
        repeat (DIV) @(negedge clock);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(6));
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        repeat (2) @(negedge clock);
        own_address = 7'($urandom_range(31, 1));
        reply_data = 8'($urandom());
        addr = {1'b0, 1'($urandom()), 1'b0, own_address[4:0]};
        if ($urandom_range(1, 0) == 1) addr = {1'b1, own_address};
        tg = '{STX_BYTE, 8'h03, addr, 8'($urandom())};
        tg.push_back(xsum(tg));
        exp_q = '{STX_BYTE, 8'h03, addr, reply_data};
        exp_q.push_back(xsum(exp_q));
        send(-1);
        `CHK("ok", 1, ok_n)
        `CHK("valid", 1, val_n)
        `CHK("rx_data", tg[4], rx_data)
        for (int k = 0; k < 100 * DIV && u_m.rx_q.size() < 5; k++) @(negedge clock);
        `CHK("reply_len", 5, u_m.rx_q.size())
        foreach (exp_q[i]) `CHK("reply_byte", exp_q[i], u_m.rx_q[i])
        `CHK("take", 1, take_n)
        `CHK("bad_frames", 0, u_m.bad_frames)
        `CHK("resp_min", 1, (t_tx - t_ok) >= GAP_BITS * DIV + DIV / 2)
        `CHK("uc_flag", 1'b0, telegram_broadcast)
        `CHK("resp_max", 1, (t_tx - t_ok) <= RESP_MAX_CYC)
        $display("test unicast done");
        repeat ((GAP_BITS + 1) * DIV) @(negedge clock);
        tg = '{STX_BYTE, 8'h02, 8'h80};
        if ($urandom_range(1, 0) == 1) tg[2] = {1'b0, 1'($urandom()), 1'b1, 5'($urandom())};
        tg.push_back(xsum(tg));
        send(-1);
        repeat (25 * DIV) @(negedge clock);
        `CHK("bc_ok", 2, ok_n)
        `CHK("bc_flag", 1'b1, telegram_broadcast)
        `CHK("bc_silent", 1, starts)
        $display("test broadcast done");
        tg = '{STX_BYTE, 8'h02};
        send(1);
        `CHK("par_err", 1, bad_n)
        `CHK("par_code", ERR_PARITY, error_code)
        tg = '{STX_BYTE, 8'h01};
        send(-1);
        `CHK("len_code", ERR_LENGTH, error_code)
        tg = '{STX_BYTE, 8'h02, addr, 8'h00};
        tg[3] = ~xsum(tg);
        send(-1);
        `CHK("chk_code", ERR_CHECK, error_code)
        `CHK("err_n", 3, bad_n)
        repeat (25 * DIV) @(negedge clock);
        `CHK("par_silent", 1, starts)
        `CHK("fault_ok", 2, ok_n)
        $display("test faults done");
        results();
    end
endmodule
